// *** lvdcap_map.svh ***
`ifndef LVDCAP_MAP_SVH
`define LVDCAP_MAP_SVH

// ****************************************************************
// Widths, timing and reset values of the input capture.
// ****************************************************************

// Width of each data path and its highest line index.
`define LVDCAP_BUS_W         16
`define LVDCAP_BUS_MSB       15

// System clock period in nanoseconds.
`define LVDCAP_CLK_NS        40

// Wait after a detected forwarded clock edge before the data lines are taken, in nanoseconds.
`define LVDCAP_SAMPLE_DLY_NS 80

// The same wait in system clock cycles, a least time rounded up.
`define LVDCAP_SAMPLE_DLY_CYC ((`LVDCAP_SAMPLE_DLY_NS + `LVDCAP_CLK_NS - 1) / `LVDCAP_CLK_NS)

// Reset values.
`define LVDCAP_CNT_RST       2'h0
`define LVDCAP_WORD_RST      16'h0000
`define LVDCAP_BIT_RST       1'h0

`endif

// *** lvdcap_pkg.sv ***
`include "lvdcap_map.svh"

package lvdcap_pkg;

	// ****************************************************************
	// Types shared by the capture and its synchroniser.
	// ****************************************************************

	typedef logic [`LVDCAP_BUS_MSB:0] lvdcap_word_t;

	// All pins that come from the far source, grouped so they cross together.
	typedef struct packed {
		logic         fclk;
		lvdcap_word_t ab;
		lvdcap_word_t cd;
		logic         strobe;
		logic         sync;
		logic         parity_cd;
	} lvdcap_pins_s;

	// One ordered sample pair, rising edge word first.
	typedef struct packed {
		lvdcap_word_t ab_rise;
		lvdcap_word_t ab_fall;
		lvdcap_word_t cd_rise;
		lvdcap_word_t cd_fall;
		logic         ab_parity;
		logic         parity_valid;
	} lvdcap_pair_s;

	// Capture sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RISE = 3'b010,
		ST_FALL = 3'b100
	} lvdcap_state_e;

endpackage

// *** lvdcap_sync.sv ***
`include "lvdcap_map.svh"

module lvdcap_sync (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire lvdcap_pkg::lvdcap_pins_s d,
	output lvdcap_pkg::lvdcap_pins_s      q
);
	import lvdcap_pkg::*;

	// ****************************************************************
	// Two flip-flop synchroniser for every pin of the link.
	// ****************************************************************

	lvdcap_pins_s s1_q;
	lvdcap_pins_s s1_d;
	lvdcap_pins_s s2_q;
	lvdcap_pins_s s2_d;

	// The first stage feeds only the second, so metastability has a full cycle to settle.
	always_comb begin
		s1_d = d;
		s2_d = s1_q;
	end

	// Both stages clear together on reset.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign q = s2_q;

endmodule

// *** lvdcap_capture.sv ***
`include "lvdcap_map.svh"

// Behaviour
// RL1: CD path carries sixteen bits on lines zero to fifteen with the forwarded clock.
// RL2: AB path carries sixteen bits on lines zero to fifteen, double data rate.
// RL3: Both paths are taken once per rising and once per falling clock edge.
// RL4: By default line fifteen is the sample MSB and line zero the LSB.
// RL5: Bus reversal mirrors the lines so line zero becomes the MSB.
// RL6: The strobe input is sampled on rising edges only.
// RL7: The sampled strobe resyncs FIFO pointers and feeds a sync source downstream.
// RL8: With parity selected the strobe is the AB path parity bit.
// RL9: The source aligns strobe transitions with both data buses' transitions.
// RL10: Interface reversal rotates the parity, sync and strobe inputs.
// RL11: Rising and falling words are joined into one ordered pair before output.
module lvdcap_capture (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    forwarded_sample_clock,
	input  wire lvdcap_pkg::lvdcap_word_t first_path_bus,
	input  wire lvdcap_pkg::lvdcap_word_t second_path_bus,
	input  wire logic                    input_strobe,
	input  wire logic                    sync_in,
	input  wire logic                    second_path_parity_in,
	input  wire logic                    bus_reverse,
	input  wire logic                    interface_reverse,
	input  wire logic                    parity_select,
	output logic                         pair_valid_q,
	output lvdcap_pkg::lvdcap_pair_s     pair_q,
	output logic                         strobe_level_q,
	output logic                         fifo_resync_q,
	output logic                         sync_source_q,
	output logic                         sync_role_q,
	output logic                         cd_parity_role_q
);
	import lvdcap_pkg::*;

	// ****************************************************************
	// Helpers.
	// ****************************************************************

	// Mirrors a path word end for end; used for both paths.
	function automatic lvdcap_word_t mirror_word(input lvdcap_word_t w);
		lvdcap_word_t r;
		r = '0;
		for (int i = 0; i <= `LVDCAP_BUS_MSB; i++) begin
			r[i] = w[`LVDCAP_BUS_MSB - i];
		end
		return r;
	endfunction

	// ****************************************************************
	// Pin crossing.
	// ****************************************************************

	lvdcap_pins_s raw_pins;
	lvdcap_pins_s pins;

	// Every pin, the forwarded clock included, passes the same two stages so they stay aligned.
	always_comb begin
		raw_pins.fclk      = forwarded_sample_clock;
		raw_pins.ab        = first_path_bus;
		raw_pins.cd        = second_path_bus;
		raw_pins.strobe    = input_strobe;
		raw_pins.sync      = sync_in;
		raw_pins.parity_cd = second_path_parity_in;
	end

	lvdcap_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (raw_pins),
		.q       (pins)
	);

	// ****************************************************************
	// Line order and input roles.
	// ****************************************************************

	lvdcap_word_t ab_now;
	lvdcap_word_t cd_now;
	logic         role_strobe;
	logic         role_sync;
	logic         role_pcd;

	// RL4 RL5 line ordering.
	// RL1 RL2 sixteen line paths.
	always_comb begin
		ab_now = bus_reverse ? mirror_word(pins.ab) : pins.ab;
		cd_now = bus_reverse ? mirror_word(pins.cd) : pins.cd;
	end

	// RL10 role rotation.
	always_comb begin
		role_strobe = interface_reverse ? pins.parity_cd : pins.strobe;
		role_sync   = interface_reverse ? pins.strobe    : pins.sync;
		role_pcd    = interface_reverse ? pins.sync      : pins.parity_cd;
	end

	// ****************************************************************
	// Edge detection and capture sequencer.
	// ****************************************************************

	lvdcap_state_e state_q;
	lvdcap_state_e state_d;
	logic [1:0]    cnt_q;
	logic [1:0]    cnt_d;
	logic          fclk_prev_q;
	logic          fclk_prev_d;
	logic          edge_rise;
	logic          edge_fall;
	lvdcap_word_t  ab_rise_q;
	lvdcap_word_t  ab_rise_d;
	lvdcap_word_t  cd_rise_q;
	lvdcap_word_t  cd_rise_d;
	logic          par_rise_q;
	logic          par_rise_d;
	logic          par_ok_q;
	logic          par_ok_d;
	logic          have_rise_q;
	logic          have_rise_d;
	logic          pair_valid_d;
	lvdcap_pair_s  pair_d;
	logic          strobe_level_d;
	logic          fifo_resync_d;
	logic          sync_source_d;
	logic          sync_role_d;
	logic          cd_parity_role_d;

	// The edge detector reads only the synchroniser output, never its first stage.
	always_comb begin
		edge_rise = pins.fclk & ~fclk_prev_q;
		edge_fall = ~pins.fclk & fclk_prev_q;
	end

	// Data is taken a quarter period after each edge, because the source aligns data to the clock edges.
	// The wait must stay shorter than half a forwarded period, or an edge would be missed.
	always_comb begin
		state_d          = state_q;
		cnt_d            = cnt_q;
		fclk_prev_d      = pins.fclk;
		ab_rise_d        = ab_rise_q;
		cd_rise_d        = cd_rise_q;
		par_rise_d       = par_rise_q;
		par_ok_d         = par_ok_q;
		have_rise_d      = have_rise_q;
		pair_valid_d     = 1'b0;
		pair_d           = pair_q;
		strobe_level_d   = strobe_level_q;
		fifo_resync_d    = 1'b0;
		sync_source_d    = 1'b0;
		sync_role_d      = sync_role_q;
		cd_parity_role_d = cd_parity_role_q;
		unique case (state_q)
			ST_IDLE: begin
				// RL3 both edges.
				if (edge_rise) begin
					state_d = ST_RISE;
					cnt_d   = 2'(`LVDCAP_SAMPLE_DLY_CYC - 1);
				end else if (edge_fall) begin
					state_d = ST_FALL;
					cnt_d   = 2'(`LVDCAP_SAMPLE_DLY_CYC - 1);
				end
			end
			ST_RISE: begin
				if (cnt_q != `LVDCAP_CNT_RST) begin
					cnt_d = cnt_q - 2'h1;
				end else begin
					state_d     = ST_IDLE;
					ab_rise_d   = ab_now;
					cd_rise_d   = cd_now;
					have_rise_d = 1'b1;
					// RL6 rising edge strobe.
					strobe_level_d   = role_strobe;
					sync_role_d      = role_sync;
					cd_parity_role_d = role_pcd;
					// RL8 strobe as parity.
					par_rise_d = role_strobe;
					par_ok_d   = parity_select;
					// RL7 resync and sync source.
					// RL9 relies on aligned strobe.
					if (!parity_select) begin
						fifo_resync_d = role_strobe & ~strobe_level_q;
						sync_source_d = role_strobe;
					end
				end
			end
			ST_FALL: begin
				if (cnt_q != `LVDCAP_CNT_RST) begin
					cnt_d = cnt_q - 2'h1;
				end else begin
					state_d = ST_IDLE;
					// RL11 ordered pair.
					if (have_rise_q) begin
						pair_valid_d        = 1'b1;
						pair_d.ab_rise      = ab_rise_q;
						pair_d.ab_fall      = ab_now;
						pair_d.cd_rise      = cd_rise_q;
						pair_d.cd_fall      = cd_now;
						pair_d.ab_parity    = par_rise_q;
						pair_d.parity_valid = par_ok_q;
					end
					have_rise_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = `LVDCAP_CNT_RST;
			end
		endcase
	end

	// Registers of the sequencer and every output.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q          <= ST_IDLE;
			cnt_q            <= `LVDCAP_CNT_RST;
			fclk_prev_q      <= `LVDCAP_BIT_RST;
			ab_rise_q        <= `LVDCAP_WORD_RST;
			cd_rise_q        <= `LVDCAP_WORD_RST;
			par_rise_q       <= `LVDCAP_BIT_RST;
			par_ok_q         <= `LVDCAP_BIT_RST;
			have_rise_q      <= `LVDCAP_BIT_RST;
			pair_valid_q     <= `LVDCAP_BIT_RST;
			pair_q           <= '0;
			strobe_level_q   <= `LVDCAP_BIT_RST;
			fifo_resync_q    <= `LVDCAP_BIT_RST;
			sync_source_q    <= `LVDCAP_BIT_RST;
			sync_role_q      <= `LVDCAP_BIT_RST;
			cd_parity_role_q <= `LVDCAP_BIT_RST;
		end else begin
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			fclk_prev_q      <= fclk_prev_d;
			ab_rise_q        <= ab_rise_d;
			cd_rise_q        <= cd_rise_d;
			par_rise_q       <= par_rise_d;
			par_ok_q         <= par_ok_d;
			have_rise_q      <= have_rise_d;
			pair_valid_q     <= pair_valid_d;
			pair_q           <= pair_d;
			strobe_level_q   <= strobe_level_d;
			fifo_resync_q    <= fifo_resync_d;
			sync_source_q    <= sync_source_d;
			sync_role_q      <= sync_role_d;
			cd_parity_role_q <= cd_parity_role_d;
		end
	end

endmodule

// *** lvdcap_capture_asserts.sv ***
module lvdcap_capture_asserts (
	input wire logic                     clk,
	input wire logic                     sys_rst,
	input wire logic                     forwarded_sample_clock,
	input wire logic                     parity_select,
	input wire logic                     pair_valid_q,
	input wire lvdcap_pkg::lvdcap_pair_s pair_q,
	input wire logic                     strobe_level_q,
	input wire logic                     fifo_resync_q,
	input wire logic                     sync_source_q
);
	timeunit 1ns;
	timeprecision 1ns;
	import lvdcap_pkg::*;
	// ****
	// Capture checks.
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// A capture needs at least six cycles, so a pair is followed by quiet.
	sequence s_quiet;
		!pair_valid_q [*5];
	endsequence
	property p_pair_pulse;
		pair_valid_q |=> s_quiet;
	endproperty
	a_pair_pulse: assert property (p_pair_pulse) else $error("pair pulse too long");
	property p_pair_hold;
		!pair_valid_q |-> $stable(pair_q);
	endproperty
	a_pair_hold: assert property (p_pair_hold) else $error("pair moved");
	// Synchroniser lag puts the causing fall four cycles back.
	property p_pair_fall;
		pair_valid_q |-> !$past(forwarded_sample_clock, 4);
	endproperty
	a_pair_fall: assert property (p_pair_fall) else $error("pair not after fall");
	property p_parity;
		pair_valid_q |-> pair_q.parity_valid == parity_select && pair_q.ab_parity == strobe_level_q;
	endproperty
	a_parity: assert property (p_parity) else $error("bad pair parity");
	property p_strobe_rise;
		sync_source_q |-> $past(forwarded_sample_clock, 4);
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("strobe not on rise");
	property p_resync;
		fifo_resync_q |-> strobe_level_q && !$past(strobe_level_q) && !parity_select;
	endproperty
	a_resync: assert property (p_resync) else $error("bad resync");
	property p_sync_src;
		sync_source_q |-> (strobe_level_q && !parity_select) ##1 !sync_source_q;
	endproperty
	a_sync_src: assert property (p_sync_src) else $error("bad sync source");
	// Reset must be seen, so this one is never disabled.
	property p_rst;
		disable iff (1'b0) sys_rst |=> !pair_valid_q && pair_q == '0 && !strobe_level_q && !fifo_resync_q;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule

bind lvdcap_capture lvdcap_capture_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
	.forwarded_sample_clock(forwarded_sample_clock), .parity_select(parity_select),
	.pair_valid_q(pair_valid_q), .pair_q(pair_q), .strobe_level_q(strobe_level_q),
	.fifo_resync_q(fifo_resync_q), .sync_source_q(sync_source_q));

// *** lvdcap_src_model.sv ***
module lvdcap_src_model (
	input  wire logic                clk,
	output lvdcap_pkg::lvdcap_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import lvdcap_pkg::*;
	// ****
	// Far source.
	// ****
	// The link clock stands low between frames.
	initial pins = '0;
	// strobe edge aligned.
	// Called on a rising system clock edge; each half period is four system clocks, 160 ns.
	task send(input lvdcap_word_t ar, af, cr, cf, input logic [2:0] ctl);
		pins.fclk <= 1'h1;
		pins.ab <= ar;
		pins.cd <= cr;
		{pins.strobe, pins.sync, pins.parity_cd} <= ctl;
		repeat (4) @(posedge clk);
		pins.fclk <= 1'h0;
		pins.ab <= af;
		pins.cd <= cf;
		// Rise-only pins flip here so a fall capture would show.
		{pins.strobe, pins.sync, pins.parity_cd} <= ~ctl;
		repeat (4) @(posedge clk);
	endtask
	// Released lines show the inverse, never the last word.
	task release_bus();
		pins.ab <= ~pins.ab;
		pins.cd <= ~pins.cd;
	endtask
endmodule

// *** tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lvdcap_pkg::*;
	typedef struct packed {
		lvdcap_word_t ar, af, cr, cf;
		logic [2:0]   ctl, mode;
		lvdcap_pair_s ep;
		logic [2:0]   er;
	} lvdcap_row_s;
	logic         clk, sys_rst, brev, irev, psel, pv, slev, rsy, ssrc, srole, cprole;
	lvdcap_pins_s pins;
	lvdcap_pair_s pair;
	lvdcap_pair_s got[$];
	int           n_fail, checks, n_rsy, n_src;
	// Mode is {bus reverse, interface reverse, parity}; ctl is {strobe, sync, cd parity}.
	// Each row ends with the pair it should give and the roles {strobe, sync, cd parity} after it.
	lvdcap_row_s  rows[4] = '{
		'{16'h8001, 16'h4321, 16'h0f0f, 16'hfe01, 3'h2, 3'h4,
			'{16'h8001, 16'h84c2, 16'hf0f0, 16'h807f, 1'h0, 1'h0}, 3'h2},
		'{16'ha5a5, 16'h5a5a, 16'h1111, 16'h2222, 3'h1, 3'h2,
			'{16'ha5a5, 16'h5a5a, 16'h1111, 16'h2222, 1'h1, 1'h0}, 3'h4},
		'{16'h0001, 16'hfffe, 16'h7777, 16'h8888, 3'h6, 3'h1,
			'{16'h0001, 16'hfffe, 16'h7777, 16'h8888, 1'h1, 1'h1}, 3'h6},
		'{16'h00f0, 16'h0f00, 16'h3c3c, 16'hc3c3, 3'h3, 3'h7,
			'{16'h0f00, 16'h00f0, 16'h3c3c, 16'hc3c3, 1'h1, 1'h1}, 3'h5}};
	lvdcap_capture uut (.clk(clk), .sys_rst(sys_rst), .forwarded_sample_clock(pins.fclk),
		.first_path_bus(pins.ab), .second_path_bus(pins.cd), .input_strobe(pins.strobe),
		.sync_in(pins.sync), .second_path_parity_in(pins.parity_cd), .bus_reverse(brev),
		.interface_reverse(irev), .parity_select(psel), .pair_valid_q(pv), .pair_q(pair),
		.strobe_level_q(slev), .fifo_resync_q(rsy), .sync_source_q(ssrc), .sync_role_q(srole),
		.cd_parity_role_q(cprole));
	lvdcap_src_model src (.clk(clk), .pins(pins));
	// ****
	// Clock, monitor and helpers.
	// ****
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	// One-cycle pulses are counted as they pass; pairs queue for later.
	always @(posedge clk) begin
		if (pv === 1'h1) got.push_back(pair);
		if (rsy === 1'h1) n_rsy++;
		if (ssrc === 1'h1) n_src++;
	end
	task chk(input logic [65:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_pairs(input int n);
		for (int k = 0; k < 30 && got.size() < n; k++) @(posedge clk);
		chk(got.size() == n, 1'h1);
	endtask
	function automatic lvdcap_word_t mir(lvdcap_word_t w, logic on);
		mir = w;
		if (on) mir = {<<{w}};
	endfunction
	function automatic logic [2:0] roles(lvdcap_row_s x);
		roles = x.mode[1] ? {x.ctl[0], x.ctl[2:1]} : x.ctl;
	endfunction
	function automatic lvdcap_pair_s exp_pair(lvdcap_row_s x);
		logic [2:0] ro;
		ro = roles(x);
		exp_pair = '{mir(x.ar, x.mode[2]), mir(x.af, x.mode[2]), mir(x.cr, x.mode[2]),
			mir(x.cf, x.mode[2]), ro[2], x.mode[0]};
	endfunction
	function automatic lvdcap_row_s burst_row(int i, int p);
		burst_row = rows[i];
		burst_row.ctl = {i != 0, 2'h0};
		burst_row.mode = {2'h0, p[0]};
	endfunction
	task give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// The sequence takes under 10 us, so 60 us means a hang.
	initial begin
		#60000;
		n_fail++;
		give_verdict();
	end
	// ****
	// Tests.
	// ****
	initial begin
		sys_rst = 1'h1;
		{brev, irev, psel} = 3'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		// One pair in each of four modes; the link changes just after a rising clock edge.
		foreach (rows[i]) begin
			{brev, irev, psel} <= rows[i].mode;
			repeat (3) @(posedge clk);
			src.send(rows[i].ar, rows[i].af, rows[i].cr, rows[i].cf, rows[i].ctl);
			src.release_bus();
			wait_pairs(1);
			chk(got.pop_front(), rows[i].ep);
			chk({slev, srole, cprole}, rows[i].er);
			$display("row %0d done", i);
			@(posedge clk);
		end
		// Back-to-back pairs; strobe pulses only while parity is off.
		for (int p = 0; p < 2; p++) begin
			{brev, irev, psel} <= {2'h0, p[0]};
			repeat (3) @(posedge clk);
			n_rsy = 0;
			n_src = 0;
			for (int i = 0; i < 3; i++) src.send(rows[i].ar, rows[i].af, rows[i].cr, rows[i].cf, {i != 0, 2'h0});
			src.release_bus();
			wait_pairs(3);
			for (int i = 0; i < 3; i++) chk(got.pop_front(), exp_pair(burst_row(i, p)));
			chk(n_rsy, p ? 0 : 1);
			chk(n_src, p ? 0 : 2);
			$display("burst %0d done", p);
			@(posedge clk);
		end
		// Reset asserted with the fall, before the rise capture is stored: nothing must come out.
		fork
			src.send(16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 3'h4);
			begin
				repeat (4) @(posedge clk);
				sys_rst <= 1'h1;
				repeat (4) @(posedge clk);
				sys_rst <= 1'h0;
			end
		join
		src.release_bus();
		repeat (12) @(posedge clk);
		chk(got.size(), 0);
		chk(pair, 0);
		chk({pv, slev, rsy, ssrc, srole, cprole}, 0);
		$display("reset done");
		give_verdict();
	end
endmodule
